// ==== src/msa_cfg.svh ====
// address map constants and timing-free figures for the memory space addressing block
`ifndef MSA_CFG_SVH
`define MSA_CFG_SVH
`define MSA_PC_W        23
`define MSA_PADDR_W     24
`define MSA_EA_W        16
`define MSA_DIR13_W     13
`define MSA_PSV_BIT     15
`define MSA_IMPL_BYTES  16384
`define MSA_RESET_PC    23'h000000
`define MSA_TARGET_PC   23'h000002
`define MSA_PC_STEP     23'h000002
`define MSA_VEC_END     23'h000200
`define MSA_IVT_BASE    23'h000004
`define MSA_IVT_LAST    23'h0000FF
`define MSA_AIVT_BASE   23'h000100
`define MSA_AIVT_LAST   23'h0001FF
`define MSA_VEC_NUM_W   7
`define MSA_VEC_MAX     7'h7D
`define MSA_SFR_LAST    16'h07FF
`define MSA_NEAR_LAST   16'h1FFF
`define MSA_BYTE_STEP   16'h0001
`define MSA_WORD_STEP   16'h0002
`endif

// ==== src/msa_pkg.sv ====
// types shared by the memory space addressing block
package msa_pkg;
  typedef enum logic [2:0] {
    ST_BOOT   = 3'b001,
    ST_TARGET = 3'b010,
    ST_RUN    = 3'b100
  } msa_state_t;
  typedef enum logic [1:0] {
    AM_DIR13   = 2'h0,
    AM_DIR16   = 2'h1,
    AM_IND     = 2'h2,
    AM_IND_INC = 2'h3
  } msa_amode_t;
  typedef enum logic [1:0] {
    EXT_NONE = 2'h0,
    EXT_SIGN = 2'h1,
    EXT_ZERO = 2'h2
  } msa_ext_t;
endpackage

// ==== src/msa_agu.sv ====
// address generation unit: effective address, pointer update and region decode
`timescale 1ns/1ps
`include "msa_cfg.svh"
module msa_agu #(
  parameter int IMPL_BYTES = `MSA_IMPL_BYTES
) (
  input  wire msa_pkg::msa_amode_t    mode_i,      // addressing mode
  input  wire logic [`MSA_EA_W-1:0]   field_i,     // direct address field
  input  wire logic [`MSA_EA_W-1:0]   ptr_i,       // working register pointer
  input  wire logic                   is_byte_i,   // byte access
  output logic      [`MSA_EA_W-1:0]   ea_o,        // effective address
  output logic      [`MSA_EA_W-1:0]   ptr_next_o,  // pointer after post-increment
  output logic                        misalign_o,  // word access to odd address
  output logic                        psv_o,       // program space window
  output logic                        impl_o,      // implemented data memory
  output logic                        sfr_o        // register region
);
  localparam logic [`MSA_EA_W:0] IMPL_LIM = (`MSA_EA_W+1)'(IMPL_BYTES);

  logic [`MSA_EA_W-1:0] step;

  always_comb begin
    step = is_byte_i ? `MSA_BYTE_STEP : `MSA_WORD_STEP; // RQ10
    ptr_next_o = ptr_i;
    unique case (mode_i)
      msa_pkg::AM_DIR13: begin
        ea_o = {{(`MSA_EA_W-`MSA_DIR13_W){1'b0}}, field_i[`MSA_DIR13_W-1:0]}; // RQ19
      end
      msa_pkg::AM_DIR16: begin
        ea_o = field_i; // RQ6 RQ20
      end
      msa_pkg::AM_IND: begin
        ea_o = ptr_i; // RQ20
      end
      msa_pkg::AM_IND_INC: begin
        ea_o = ptr_i;
        ptr_next_o = ptr_i + step; // RQ10
      end
    endcase
    misalign_o = !is_byte_i && ea_o[0]; // RQ13
    psv_o = ea_o[`MSA_PSV_BIT]; // RQ7
    impl_o = !ea_o[`MSA_PSV_BIT] && ({1'b0, ea_o} < IMPL_LIM); // RQ7 RQ8
    sfr_o = ea_o <= `MSA_SFR_LAST; // RQ17
  end
endmodule

// ==== src/msa_mem_map.sv ====
// program counter, vector dispatch and data space access alignment for the core
//
// Functional notes
// (RQ1) program word splits into lower and upper halves
// (RQ2) program counter even, steps by two
// (RQ3) boot at zero, target word at two
// (RQ4) addresses below 0x200 hold fixed vectors
// (RQ5) primary and alternate vector tables per source
// (RQ6) effective address is sixteen bits, byte granular
// (RQ7) bit fifteen selects program space window
// (RQ8) reads outside implemented memory return zero
// (RQ9) low byte even address, high byte odd
// (RQ10) post-increment adds one or two by size
// (RQ11) byte read selects lane, returns low byte
// (RQ12) shared word decode, per-byte write strobes
// (RQ13) odd word access raises address error trap
// (RQ14) misaligned read completes, misaligned write suppressed
// (RQ15) byte load keeps working register high byte
// (RQ16) sign extend and zero extend of byte
// (RQ17) low 2 Kbytes decode as register space
// (RQ18) unused register addresses read zero
// (RQ19) thirteen-bit direct field reaches near space
// (RQ20) sixteen-bit direct or indirect reaches everything
// (RQ21) separate read and write address units
// (RQ22) 24-bit program address from 23-bit counter
`timescale 1ns/1ps
`include "msa_cfg.svh"
module msa_mem_map #(
  parameter int IMPL_BYTES = `MSA_IMPL_BYTES,
  parameter int MEM_AW     = $clog2(IMPL_BYTES) - 1
) (
  input  wire logic                     ref_clk_i,       // core clock
  input  wire logic                     reset_n_i,       // async reset, active low
  input  wire logic                     pc_step_i,       // advance one instruction
  input  wire logic                     pc_back_i,       // retreat one instruction
  input  wire logic                     pc_load_i,       // load branch target
  input  wire logic [`MSA_PC_W-1:0]     pc_load_addr_i,  // branch target
  input  wire logic                     vec_take_i,      // dispatch to vector
  input  wire logic                     vec_alt_i,       // use alternate table
  input  wire logic [`MSA_VEC_NUM_W-1:0] vec_num_i,      // interrupt source number
  input  wire logic                     tbl_rd_i,        // table read of program memory
  input  wire logic [`MSA_PADDR_W-1:0]  tbl_addr_i,      // table read address
  input  wire logic [`MSA_PADDR_W-1:0]  prog_data_i,     // program memory word
  output logic      [`MSA_PADDR_W-1:0]  prog_addr_o,     // program memory address
  output logic      [`MSA_PC_W-1:0]     program_counter_o, // current counter
  output logic                          pc_in_vectors_o, // counter in vector area
  output logic                          boot_done_o,     // reset jump resolved
  output logic      [15:0]              tbl_data_o,      // table read result
  output logic                          tbl_valid_o,     // table result strobe
  input  wire logic                     rd_req_i,        // data read request
  input  wire logic                     rd_byte_i,       // byte read
  input  wire msa_pkg::msa_amode_t      rd_mode_i,       // read addressing mode
  input  wire logic [`MSA_EA_W-1:0]     rd_field_i,      // read direct field
  input  wire logic [`MSA_EA_W-1:0]     rd_ptr_i,        // read pointer
  input  wire msa_pkg::msa_ext_t        rd_ext_i,        // extend on load
  input  wire logic [15:0]              rd_wreg_i,       // destination register value
  input  wire logic                     wr_req_i,        // data write request
  input  wire logic                     wr_byte_i,       // byte write
  input  wire msa_pkg::msa_amode_t      wr_mode_i,       // write addressing mode
  input  wire logic [`MSA_EA_W-1:0]     wr_field_i,      // write direct field
  input  wire logic [`MSA_EA_W-1:0]     wr_ptr_i,        // write pointer
  input  wire logic [15:0]              wr_data_i,       // write data, byte in low lane
  output logic                          mem_re_o,        // data memory read
  output logic      [MEM_AW-1:0]        mem_raddr_o,     // read word address
  output logic                          mem_rsfr_o,      // read hits register region
  input  wire logic [15:0]              mem_rdata_i,     // data memory word
  input  wire logic                     sfr_ack_i,       // register implemented
  output logic                          mem_we_o,        // data memory write
  output logic      [MEM_AW-1:0]        mem_waddr_o,     // write word address
  output logic      [1:0]               mem_be_o,        // byte lane strobes
  output logic      [15:0]              mem_wdata_o,     // write word
  output logic                          psv_re_o,        // window read
  output logic      [`MSA_PSV_BIT-1:0]  psv_addr_o,      // window byte address
  input  wire logic [15:0]              psv_rdata_i,     // window word
  output logic      [`MSA_EA_W-1:0]     rd_ptr_next_o,   // read pointer update
  output logic      [`MSA_EA_W-1:0]     wr_ptr_next_o,   // write pointer update
  output logic                          rd_valid_o,      // read data strobe
  output logic      [15:0]              rd_data_o,       // placed read data
  output logic      [15:0]              wreg_data_o,     // merged register value
  output logic                          addr_err_trap_o  // address error trap pulse
);
  msa_pkg::msa_state_t state;
  msa_pkg::msa_state_t next_state;
  logic [`MSA_PC_W-1:0] pc;
  logic [`MSA_PC_W-1:0] next_pc;
  logic [`MSA_PC_W-1:0] vec_addr;
  logic [`MSA_VEC_NUM_W-1:0] vec_idx;

  // vector slot past the table end would alias the next region
  function automatic logic [`MSA_VEC_NUM_W-1:0] clamp_vec(input logic [`MSA_VEC_NUM_W-1:0] n);
    return (n > `MSA_VEC_MAX) ? `MSA_VEC_MAX : n;
  endfunction

  function automatic logic [`MSA_PC_W-1:0] even(input logic [`MSA_PC_W-1:0] a);
    return {a[`MSA_PC_W-1:1], 1'b0};
  endfunction

  always_comb begin
    vec_idx = clamp_vec(vec_num_i);
    vec_addr = (vec_alt_i ? `MSA_AIVT_BASE : `MSA_IVT_BASE)
             + {{(`MSA_PC_W-`MSA_VEC_NUM_W-1){1'b0}}, vec_idx, 1'b0}; // RQ5
    next_state = state;
    next_pc = pc;
    unique case (state)
      msa_pkg::ST_BOOT: begin
        next_state = msa_pkg::ST_TARGET;
        next_pc = `MSA_TARGET_PC; // RQ3
      end
      msa_pkg::ST_TARGET: begin
        next_state = msa_pkg::ST_RUN;
        next_pc = even(prog_data_i[`MSA_PC_W-1:0]); // RQ3
      end
      msa_pkg::ST_RUN: begin
        if (tbl_rd_i) begin
          next_pc = pc;
        end else if (vec_take_i) begin
          next_pc = vec_addr; // RQ4 RQ5
        end else if (pc_load_i) begin
          next_pc = even(pc_load_addr_i); // RQ2
        end else if (pc_step_i) begin
          next_pc = pc + `MSA_PC_STEP; // RQ2
        end else if (pc_back_i) begin
          next_pc = pc - `MSA_PC_STEP; // RQ2
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= msa_pkg::ST_BOOT;
      pc <= `MSA_RESET_PC; // RQ3
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  // program memory is read combinationally; a table read borrows the port
  always_comb begin
    if (tbl_rd_i && state == msa_pkg::ST_RUN) begin
      prog_addr_o = {tbl_addr_i[`MSA_PADDR_W-1:1], 1'b0}; // RQ1
    end else begin
      prog_addr_o = {1'b0, pc}; // RQ22
    end
  end
  assign program_counter_o = pc;
  assign pc_in_vectors_o = pc < `MSA_VEC_END; // RQ4
  assign boot_done_o = state == msa_pkg::ST_RUN;

  logic [15:0] next_tbl_data;
  logic        next_tbl_valid;

  always_comb begin
    next_tbl_valid = tbl_rd_i && state == msa_pkg::ST_RUN;
    next_tbl_data = tbl_data_o;
    if (next_tbl_valid) begin
      // upper half carries only eight implemented bits
      next_tbl_data = tbl_addr_i[0] ? {8'h00, prog_data_i[23:16]} : prog_data_i[15:0]; // RQ1
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbl_data_o <= 16'h0000;
      tbl_valid_o <= 1'b0;
    end else begin
      tbl_data_o <= next_tbl_data;
      tbl_valid_o <= next_tbl_valid;
    end
  end

  logic [`MSA_EA_W-1:0] rd_ea, wr_ea, rd_pn, wr_pn;
  logic                 rd_mis, rd_psv, rd_impl, rd_sfr;
  logic                 wr_mis, wr_impl;

  msa_agu #(.IMPL_BYTES(IMPL_BYTES)) u_rd_agu ( // RQ21
    .mode_i     (rd_mode_i),
    .field_i    (rd_field_i),
    .ptr_i      (rd_ptr_i),
    .is_byte_i  (rd_byte_i),
    .ea_o       (rd_ea),
    .ptr_next_o (rd_pn),
    .misalign_o (rd_mis),
    .psv_o      (rd_psv),
    .impl_o     (rd_impl),
    .sfr_o      (rd_sfr)
  );

  msa_agu #(.IMPL_BYTES(IMPL_BYTES)) u_wr_agu ( // RQ21
    .mode_i     (wr_mode_i),
    .field_i    (wr_field_i),
    .ptr_i      (wr_ptr_i),
    .is_byte_i  (wr_byte_i),
    .ea_o       (wr_ea),
    .ptr_next_o (wr_pn),
    .misalign_o (wr_mis),
    .psv_o      (),
    .impl_o     (wr_impl),
    .sfr_o      ()
  );

  // stage 1: address registered toward the memories
  logic                 r1_valid, r1_byte, r1_impl, r1_psv, r1_sfr;
  logic [`MSA_EA_W-1:0] r1_ea;
  msa_pkg::msa_ext_t    r1_ext;
  logic [15:0]          r1_wold;
  logic                 w1_valid, w1_byte, w1_ok;
  logic [`MSA_EA_W-1:0] w1_ea;
  logic [15:0]          w1_data;
  logic                 next_trap;

  always_comb begin
    next_trap = (rd_req_i && rd_mis) || (wr_req_i && wr_mis); // RQ13
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r1_valid <= 1'b0;
      r1_byte <= 1'b0;
      r1_impl <= 1'b0;
      r1_psv <= 1'b0;
      r1_sfr <= 1'b0;
      r1_ea <= 16'h0000;
      r1_ext <= msa_pkg::EXT_NONE;
      r1_wold <= 16'h0000;
      w1_valid <= 1'b0;
      w1_byte <= 1'b0;
      w1_ok <= 1'b0;
      w1_ea <= 16'h0000;
      w1_data <= 16'h0000;
      rd_ptr_next_o <= 16'h0000;
      wr_ptr_next_o <= 16'h0000;
      addr_err_trap_o <= 1'b0;
    end else begin
      r1_valid <= rd_req_i;
      r1_byte <= rd_byte_i;
      r1_impl <= rd_impl;
      r1_psv <= rd_psv;
      r1_sfr <= rd_sfr;
      r1_ea <= rd_ea;
      r1_ext <= rd_ext_i;
      r1_wold <= rd_wreg_i;
      w1_valid <= wr_req_i;
      w1_byte <= wr_byte_i;
      w1_ok <= wr_impl && !wr_mis; // RQ14
      w1_ea <= wr_ea;
      w1_data <= wr_data_i;
      rd_ptr_next_o <= rd_pn;
      wr_ptr_next_o <= wr_pn;
      addr_err_trap_o <= next_trap;
    end
  end

  // one word decode for memory and registers; lanes only split on write
  assign mem_re_o = r1_valid && r1_impl; // RQ12
  assign mem_raddr_o = r1_ea[MEM_AW:1];
  assign mem_rsfr_o = r1_valid && r1_sfr;
  assign psv_re_o = r1_valid && r1_psv; // RQ7
  assign psv_addr_o = r1_ea[`MSA_PSV_BIT-1:0];
  assign mem_we_o = w1_valid && w1_ok; // RQ14
  assign mem_waddr_o = w1_ea[MEM_AW:1];
  assign mem_be_o = w1_byte ? (w1_ea[0] ? 2'b10 : 2'b01) : 2'b11; // RQ9 RQ12
  assign mem_wdata_o = w1_byte ? {w1_data[7:0], w1_data[7:0]} : w1_data;

  // stage 2: lane select and register merge
  logic [15:0] src_word, next_rd_data, next_wreg;
  logic [7:0]  sel_byte;

  always_comb begin
    if (r1_impl) begin
      src_word = (r1_sfr && !sfr_ack_i) ? 16'h0000 : mem_rdata_i; // RQ18
    end else if (r1_psv) begin
      src_word = psv_rdata_i;
    end else begin
      src_word = 16'h0000; // RQ8
    end
    sel_byte = r1_ea[0] ? src_word[15:8] : src_word[7:0]; // RQ9 RQ11
    next_rd_data = r1_byte ? {8'h00, sel_byte} : src_word; // RQ11
    unique case (r1_ext)
      msa_pkg::EXT_SIGN: next_wreg = {{8{next_rd_data[7]}}, next_rd_data[7:0]}; // RQ16
      msa_pkg::EXT_ZERO: next_wreg = {8'h00, next_rd_data[7:0]}; // RQ16
      default: next_wreg = r1_byte ? {r1_wold[15:8], sel_byte} : src_word; // RQ15
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
      wreg_data_o <= 16'h0000;
    end else begin
      rd_valid_o <= r1_valid; // RQ14
      rd_data_o <= next_rd_data;
      wreg_data_o <= next_wreg;
    end
  end

  chk_pc_even_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ2
    state == msa_pkg::ST_RUN && pc_step_i && !tbl_rd_i && !vec_take_i && !pc_load_i
    |=> pc == $past(pc) + `MSA_PC_STEP && pc[0] == 1'b0)
    else $error("counter did not step by two");

  chk_boot_sequence: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ3
    state == msa_pkg::ST_BOOT |-> prog_addr_o == 24'h000000 ##1 prog_addr_o == 24'h000002)
    else $error("boot fetch order wrong");

  logic vec_alt_i_d;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vec_alt_i_d <= 1'b0;
    end else begin
      vec_alt_i_d <= vec_alt_i;
    end
  end

  chk_vector_range: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ5
    state == msa_pkg::ST_RUN && vec_take_i && !tbl_rd_i
    |=> pc >= `MSA_IVT_BASE && pc <= (vec_alt_i_d ? `MSA_AIVT_LAST : `MSA_IVT_LAST))
    else $error("vector outside its table");

  chk_write_suppress: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ14
    wr_req_i && !wr_byte_i && wr_ea[0] |=> !mem_we_o && addr_err_trap_o)
    else $error("misaligned write reached memory");

  chk_read_completes: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ13
    rd_req_i && !rd_byte_i && rd_ea[0] |=> addr_err_trap_o ##1 rd_valid_o)
    else $error("misaligned read lost");

  chk_byte_strobe: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ12
    wr_req_i && wr_byte_i && wr_impl |=> mem_we_o && mem_be_o == ($past(wr_ea[0]) ? 2'b10 : 2'b01))
    else $error("byte write strobe wrong lane");

  chk_outside_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ8
    rd_req_i && !rd_impl && !rd_psv |=> ##1 rd_data_o == 16'h0000)
    else $error("unimplemented read not zero");

  chk_byte_high_keep: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ15
    rd_req_i && rd_byte_i && rd_ext_i == msa_pkg::EXT_NONE
    |=> ##1 wreg_data_o[15:8] == $past(rd_wreg_i[15:8], 2) && rd_data_o[15:8] == 8'h00)
    else $error("byte load touched high byte");

  chk_sign_extend: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ16
    r1_valid && r1_ext == msa_pkg::EXT_SIGN |=> wreg_data_o[15:8] == {8{wreg_data_o[7]}})
    else $error("sign extend wrong");

  chk_window_route: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ7
    rd_req_i && rd_ea[15] |=> psv_re_o && !mem_re_o)
    else $error("window read misrouted");

  chk_post_increment: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // RQ10
    rd_req_i && rd_mode_i == msa_pkg::AM_IND_INC
    |=> rd_ptr_next_o == 16'($past(rd_ptr_i) + ($past(rd_byte_i) ? 16'h0001 : 16'h0002)))
    else $error("pointer step wrong");
endmodule

// ==== test/msa_mem_model.sv ====
// memory side model: program words, data array, register ack and window data
`timescale 1ns/1ps
module msa_mem_model (
  input  wire logic        ref_clk_i,   // core clock
  input  wire logic [23:0] prog_addr_i, // program address
  output logic      [23:0] prog_data_o, // program word
  input  wire logic        re_i,        // data read
  input  wire logic [12:0] raddr_i,     // read word address
  output logic      [15:0] rdata_o,     // read word
  output logic             sfr_ack_o,   // register implemented
  input  wire logic        we_i,        // data write
  input  wire logic [12:0] waddr_i,     // write word address
  input  wire logic [1:0]  be_i,        // lane strobes
  input  wire logic [15:0] wdata_i,     // write word
  input  wire logic        psv_re_i,    // window read
  input  wire logic [14:0] psv_addr_i,  // window byte address
  output logic      [15:0] psv_data_o   // window word
);
  logic [15:0] ram [0:8191];
  // word two holds the boot target, every other word encodes its own address
  assign prog_data_o = (prog_addr_i == 24'h000002) ? 24'h000A41 :
                       {~prog_addr_i[7:0], prog_addr_i[15:0]};
  // idle bus shows inverted data so a late sample cannot pass
  assign rdata_o    = re_i ? ram[raddr_i] : ~ram[raddr_i];
  assign sfr_ack_o  = ~raddr_i[4];
  assign psv_data_o = psv_re_i ? {psv_addr_i[14:1], 2'b10} : 16'h5A5A;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      ram[i] = 16'h0000;
    end
  end
  always @(posedge ref_clk_i) begin
    if (we_i && be_i[0]) begin
      ram[waddr_i][7:0] <= wdata_i[7:0];
    end
    if (we_i && be_i[1]) begin
      ram[waddr_i][15:8] <= wdata_i[15:8];
    end
  end
endmodule

// ==== test/msa_mem_map_bench.sv ====
// self-checking bench for the memory space addressing block
`timescale 1ns/1ps
module msa_mem_map_bench;
  logic ref_clk_i, reset_n_i, pc_step_i, pc_back_i, pc_load_i, vec_take_i, vec_alt_i, tbl_rd_i;
  logic rd_req_i, rd_byte_i, wr_req_i, wr_byte_i, mem_re_o, mem_rsfr_o, sfr_ack_i, mem_we_o;
  logic psv_re_o, pc_in_vectors_o, boot_done_o, tbl_valid_o, rd_valid_o, addr_err_trap_o;
  logic [22:0] pc_load_addr_i, program_counter_o, epc;
  logic [6:0]  vec_num_i;
  logic [23:0] tbl_addr_i, prog_data_i, prog_addr_o;
  logic [15:0] rd_field_i, rd_ptr_i, rd_wreg_i, wr_field_i, wr_ptr_i, wr_data_i, mem_rdata_i;
  logic [15:0] mem_wdata_o, psv_rdata_i, rd_ptr_next_o, wr_ptr_next_o, rd_data_o, wreg_data_o;
  logic [15:0] tbl_data_o, r;
  logic [12:0] mem_raddr_o, mem_waddr_o;
  logic [1:0]  mem_be_o;
  logic [14:0] psv_addr_o;
  logic [15:0] sh [0:8191];
  msa_pkg::msa_amode_t rd_mode_i, wr_mode_i, m;
  msa_pkg::msa_ext_t   rd_ext_i;
  int n_fail, check_count, seed;
  msa_mem_map i_msa_mem_map (.ref_clk_i, .reset_n_i, .pc_step_i, .pc_back_i, .pc_load_i,
    .pc_load_addr_i, .vec_take_i, .vec_alt_i, .vec_num_i, .tbl_rd_i, .tbl_addr_i, .prog_data_i,
    .prog_addr_o, .program_counter_o, .pc_in_vectors_o, .boot_done_o, .tbl_data_o, .tbl_valid_o,
    .rd_req_i, .rd_byte_i, .rd_mode_i, .rd_field_i, .rd_ptr_i, .rd_ext_i, .rd_wreg_i, .wr_req_i,
    .wr_byte_i, .wr_mode_i, .wr_field_i, .wr_ptr_i, .wr_data_i, .mem_re_o, .mem_raddr_o,
    .mem_rsfr_o, .mem_rdata_i, .sfr_ack_i, .mem_we_o, .mem_waddr_o, .mem_be_o, .mem_wdata_o,
    .psv_re_o, .psv_addr_o, .psv_rdata_i, .rd_ptr_next_o, .wr_ptr_next_o, .rd_valid_o,
    .rd_data_o, .wreg_data_o, .addr_err_trap_o);
  msa_mem_model i_msa_mem_model (.ref_clk_i(ref_clk_i), .prog_addr_i(prog_addr_o),
    .prog_data_o(prog_data_i), .re_i(mem_re_o), .raddr_i(mem_raddr_o), .rdata_o(mem_rdata_i),
    .sfr_ack_o(sfr_ack_i), .we_i(mem_we_o), .waddr_i(mem_waddr_o), .be_i(mem_be_o),
    .wdata_i(mem_wdata_o), .psv_re_i(psv_re_o), .psv_addr_i(psv_addr_o),
    .psv_data_o(psv_rdata_i));
  task automatic chk_word(input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_flag(input logic e, input logic g);
    chk_word(e, g);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] ea_of(input msa_pkg::msa_amode_t md, input logic [15:0] f, p);
    if (md == msa_pkg::AM_DIR13) return {3'h0, f[12:0]};
    return (md == msa_pkg::AM_DIR16) ? f : p;
  endfunction
  function automatic logic [15:0] ptr_of(input msa_pkg::msa_amode_t md, input logic [15:0] p,
                                         input logic b);
    return (md == msa_pkg::AM_IND_INC) ? p + (b ? 16'h0001 : 16'h0002) : p;
  endfunction
  function automatic logic [15:0] rword(input logic [15:0] ea);
    if (ea[15]) return {ea[14:1], 2'b10};
    if (ea >= 16'h4000) return 16'h0000;
    if (ea <= 16'h07FF && ea[5]) return 16'h0000;
    return sh[ea[13:1]];
  endfunction
  task automatic do_read(input logic b, input msa_pkg::msa_amode_t md, input logic [15:0] f, p,
                         input msa_pkg::msa_ext_t x, input logic [15:0] w);
    logic [15:0] ea, wd, d, ew;
    ea = ea_of(md, f, p);
    wd = rword(ea);
    d = b ? {8'h00, ea[0] ? wd[15:8] : wd[7:0]} : wd;
    ew = b ? {w[15:8], d[7:0]} : d;
    if (x == msa_pkg::EXT_SIGN) ew = {{8{d[7]}}, d[7:0]};
    if (x == msa_pkg::EXT_ZERO) ew = {8'h00, d[7:0]};
    @(posedge ref_clk_i);
    rd_req_i <= 1'b1;
    rd_byte_i <= b;
    rd_mode_i <= md;
    rd_field_i <= f;
    rd_ptr_i <= p;
    rd_ext_i <= x;
    rd_wreg_i <= w;
    @(posedge ref_clk_i);
    rd_req_i <= 1'b0;
    #1;
    chk_flag(!b && ea[0], addr_err_trap_o);
    chk_flag(ea[15], psv_re_o);
    chk_flag(ea <= 16'h07FF, mem_rsfr_o);
    chk_word(ptr_of(md, p, b), rd_ptr_next_o);
    @(posedge ref_clk_i);
    #1;
    chk_flag(1'b1, rd_valid_o);
    chk_word(d, rd_data_o);
    chk_word(ew, wreg_data_o);
  endtask
  task automatic do_write(input logic b, input msa_pkg::msa_amode_t md, input logic [15:0] f, p, d);
    logic [15:0] ea;
    logic        ok;
    logic [1:0]  be;
    ea = ea_of(md, f, p);
    ok = (b || !ea[0]) && ea < 16'h4000;
    be = b ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
    @(posedge ref_clk_i);
    wr_req_i <= 1'b1;
    wr_byte_i <= b;
    wr_mode_i <= md;
    wr_field_i <= f;
    wr_ptr_i <= p;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_req_i <= 1'b0;
    #1;
    chk_flag(ok, mem_we_o);
    chk_flag(!b && ea[0], addr_err_trap_o);
    chk_word(ptr_of(md, p, b), wr_ptr_next_o);
    if (ok) begin
      chk_word(ea[13:1], mem_waddr_o);
      chk_word(be, mem_be_o);
      if (be[0]) sh[ea[13:1]][7:0] = d[7:0];
      if (be[1]) sh[ea[13:1]][15:8] = b ? d[7:0] : d[15:8];
    end
  endtask
  task automatic pc_op(input logic [3:0] op, input logic [22:0] a, input logic [6:0] n,
                       input logic alt);
    @(posedge ref_clk_i);
    {vec_take_i, pc_load_i, pc_back_i, pc_step_i} <= op;
    pc_load_addr_i <= a;
    vec_num_i <= n;
    vec_alt_i <= alt;
    if (op[3]) epc = (alt ? 23'h000100 : 23'h000004) + {15'h0, (n > 7'h7D ? 7'h7D : n), 1'b0};
    else if (op[2]) epc = {a[22:1], 1'b0};
    else if (op[0]) epc = epc + 23'h000002;
    else if (op[1]) epc = epc - 23'h000002;
    @(posedge ref_clk_i);
    {vec_take_i, pc_load_i, pc_back_i, pc_step_i} <= 4'h0;
    #1;
    chk_word(epc, program_counter_o);
    chk_word({1'b0, epc}, prog_addr_o);
    chk_flag(epc < 23'h000200, pc_in_vectors_o);
  endtask
  task automatic tbl(input logic [23:0] a);
    logic [23:0] q, pw;
    q = {a[23:1], 1'b0};
    pw = (q == 24'h000002) ? 24'h000A41 : {~q[7:0], q[15:0]};
    @(posedge ref_clk_i);
    tbl_rd_i <= 1'b1;
    tbl_addr_i <= a;
    @(posedge ref_clk_i);
    tbl_rd_i <= 1'b0;
    #1;
    chk_flag(1'b1, tbl_valid_o);
    chk_word(a[0] ? {16'h0000, pw[23:16]} : {8'h00, pw[15:0]}, tbl_data_o);
    chk_word(epc, program_counter_o);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    seed = 93;
    {reset_n_i, pc_step_i, pc_back_i, pc_load_i, vec_take_i, vec_alt_i, tbl_rd_i} = 7'h00;
    {rd_req_i, rd_byte_i, wr_req_i, wr_byte_i, pc_load_addr_i, vec_num_i, tbl_addr_i} = '0;
    {rd_field_i, rd_ptr_i, rd_wreg_i, wr_field_i, wr_ptr_i, wr_data_i} = '0;
    rd_mode_i = msa_pkg::AM_DIR13;
    wr_mode_i = msa_pkg::AM_DIR13;
    rd_ext_i = msa_pkg::EXT_NONE;
    for (int i = 0; i < 8192; i++) sh[i] = 16'h0000;
    repeat (5) @(posedge ref_clk_i);
    #1;
    chk_word(24'h000000, prog_addr_o);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk_word(23'h000002, program_counter_o);
    @(posedge ref_clk_i);
    #1;
    chk_word(23'h000A40, program_counter_o);
    chk_flag(1'b1, boot_done_o);
    epc = 23'h000A40;
    // priority: step over back, load over step, vector over load
    for (int k = 0; k < 6; k++) pc_op(4'(24'h11235C >> (20 - 4 * k)), 23'h012345, 7'h10, 1'b0);
    for (int j = 0; j < 12; j++) pc_op(4'h8, 23'h0, (j % 6 < 3) ? 7'(j % 6) : 7'(122 + j % 6),
      j >= 6);
    for (int j = 0; j < 20; j++) pc_op(4'h1 << ({$random(seed)} % 4), 23'($random(seed)),
      7'($random(seed)), 1'($random(seed)));
    tbl(24'h000101);
    tbl(24'h000100);
    for (int j = 0; j < 6; j++) tbl(24'($random(seed)));
    do_write(1'b0, msa_pkg::AM_DIR16, 16'h0800, 16'h0, 16'h1234);
    do_write(1'b1, msa_pkg::AM_DIR13, 16'hE801, 16'h0, 16'h00AB);
    do_read(1'b0, msa_pkg::AM_IND, 16'h0, 16'h0800, msa_pkg::EXT_NONE, 16'h5555);
    do_read(1'b1, msa_pkg::AM_IND_INC, 16'h0, 16'h0801, msa_pkg::EXT_SIGN, 16'h5555);
    do_read(1'b1, msa_pkg::AM_DIR16, 16'h0800, 16'h0, msa_pkg::EXT_ZERO, 16'h5555);
    do_write(1'b0, msa_pkg::AM_DIR16, 16'h0803, 16'h0, 16'hBEEF);
    do_read(1'b0, msa_pkg::AM_DIR16, 16'h0803, 16'h0, msa_pkg::EXT_NONE, 16'h0);
    do_write(1'b0, msa_pkg::AM_DIR16, 16'h0020, 16'h0, 16'h7777);
    do_read(1'b0, msa_pkg::AM_DIR16, 16'h0020, 16'h0, msa_pkg::EXT_NONE, 16'h0);
    do_write(1'b0, msa_pkg::AM_DIR16, 16'h4000, 16'h0, 16'h7777);
    do_read(1'b0, msa_pkg::AM_DIR16, 16'h4000, 16'h0, msa_pkg::EXT_NONE, 16'h0);
    do_read(1'b1, msa_pkg::AM_IND, 16'h0, 16'h8003, msa_pkg::EXT_NONE, 16'hA5A5);
    for (int j = 0; j < 60; j++) begin
      r = 16'($random(seed)) & ((j % 4 == 0) ? 16'hFFFF : 16'h07FF);
      m = msa_pkg::msa_amode_t'(2'($random(seed)));
      do_write(j[0], m, r, r, 16'($random(seed)));
      do_read(j[1], m, r, r, msa_pkg::msa_ext_t'(2'({$random(seed)} % 3)),
        16'($random(seed)));
    end
    tally_and_finish;
  end
endmodule
